// File: bench/testbench.sv
// self-checking bench for the output compare unit
`include "toc_defs.svh"
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin fail_count++; $display("[ERR] %0t %h vs %h", $time, a, e); end end
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0, rst = 1'b1, ce = 1'b1, tick = 1'b0, oack = 1'b0, prdy, perr, oirq;
	logic [15:0] cap;
	logic [31:0] prdata;
	logic [2:0] cack = 3'h0, pval, pdir, pin, oe, cirq;
	logic psel, pen, pwr;
	logic [7:0] paddr;
	logic [31:0] pwdata;
	logic [1:0] ac [4] = '{2'h2, 2'h3, 2'h0, 2'h1};
	logic [3:0] ex;
	logic [32:0] q [$];
	logic [32:0] e;
	int fail_count = 0, checks = 0, cyc = 0;
	always #12.5 clk = ~clk;
	toc_cpu cpu (.clk_in(clk), .pready_in(prdy), .psel_out(psel), .penable_out(pen), .pwrite_out(pwr),
		.paddr_out(paddr), .pwdata_out(pwdata));
	toc_unit dut (.core_clk_in(clk), .sys_rst_in(rst), .core_ce_in(ce), .timer_tick_in(tick),
		.capture_value_in(cap), .psel_in(psel), .penable_in(pen),
		.pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata),
		.prdata_out(prdata), .pready_out(prdy), .pslverr_out(perr), .compare_irq_ack_in(cack),
		.overflow_irq_ack_in(oack), .port_value_in(pval), .pin_direction_bit_in(pdir), .pin_out_out(pin),
		.pin_oe_out(oe), .compare_irq_out(cirq), .overflow_irq_out(oirq));
	task stop_test;
		$display("checks %0d fails %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	task rd(input logic [7:0] a, input logic [32:0] x);
		q.push_back(x);
		cpu.xfer(1'b0, a, 32'h0);
	endtask
	task tk(input int n);
		repeat (n) begin
			@(posedge clk);
			tick <= 1'b1;
			@(posedge clk);
			tick <= 1'b0;
		end
	endtask
	task pin_chk(input logic x);
		@(posedge clk);
		`CHK(pin[0], x)
	endtask
	// *****
	// read results leave the queue in order
	// *****
	always @(posedge clk) begin
		cyc++;
		if (prdy && !pwr) begin
			e = q.pop_front();
			`CHK({perr, prdata}, e)
		end
		if (cyc == 3000) begin
			fail_count++;
			stop_test;
		end
	end
	initial begin
		void'($urandom(32'h08c900a5));
		cap <= 16'($urandom);
		pval <= 3'($urandom);
		pdir <= 3'($urandom);
		repeat (10) @(posedge clk);
		ex = {1'b0, pval[0], 1'b1, 1'b0};
		rst <= 1'b0;
		rd(`TOC_OFF_CTRL, 33'h0);
		rd(`TOC_OFF_FLAG, 33'h0);
		rd(8'h30, 33'h100000000);
		pin_chk(pval[0]);
		`CHK(oe, pdir)
		$display("test 1 done");
		cpu.xfer(1'b1, `TOC_OFF_IEN, 32'h8);
		cpu.w16(`TOC_OFF_CNT_L, 16'hfffe); // normal mode only
		tk(2);
		rd(`TOC_OFF_FLAG, 33'h8);
		`CHK(oirq, 1'b1)
		rd(`TOC_OFF_CNT_L, 33'h0);
		rd(`TOC_OFF_CNT_H, 33'h0);
		cpu.xfer(1'b1, `TOC_OFF_FLAG, 32'h8);
		rd(`TOC_OFF_FLAG, 33'h0);
		$display("test 2 done");
		cpu.xfer(1'b1, `TOC_OFF_CTRL, 32'h10);
		cpu.w16(`TOC_OFF_CMP_L, 16'h0105);
		rd(`TOC_OFF_CMP_H, 33'h1);
		rd(`TOC_OFF_CMP_L, 33'h5);
		cpu.xfer(1'b1, `TOC_OFF_IEN, 32'h1);
		cpu.w16(`TOC_OFF_CNT_L, 16'h0103);
		tk(2);
		rd(`TOC_OFF_FLAG, 33'h0);
		tk(1);
		rd(`TOC_OFF_FLAG, 33'h1);
		pin_chk(1'b1);
		`CHK(cirq[0], 1'b1)
		@(posedge clk);
		cack <= 3'h1;
		@(posedge clk);
		cack <= 3'h0;
		@(posedge clk);
		`CHK(cirq[0], 1'b0)
		cpu.w16(`TOC_OFF_CNT_L, 16'h0105);
		tk(1);
		rd(`TOC_OFF_FLAG, 33'h0);
		pin_chk(1'b1);
		$display("test 3 done");
		for (int i = 0; i < 4; i++) begin
			cpu.xfer(1'b1, `TOC_OFF_CTRL, {26'h0, ac[i], 4'h0});
			cpu.xfer(1'b1, `TOC_OFF_FORCE, 32'h1);
			pin_chk(ex[i]);
		end
		rd(`TOC_OFF_FLAG, 33'h0);
		cpu.xfer(1'b1, `TOC_OFF_CTRL, 32'h35);
		pin_chk(1'b0);
		rd(`TOC_OFF_CTRL, 33'h35);
		$display("test 4 done");
		// fast pwm, ceiling 0xff: the write must wait in the buffer until the ceiling
		cpu.w16(`TOC_OFF_CMP_L, 16'h0010);
		rd(`TOC_OFF_CMP_L, 33'h10);
		cpu.w16(`TOC_OFF_CNT_L, 16'h00fe);
		tk(2);
		pin_chk(1'b0);
		tk(17);
		pin_chk(1'b1);
		rd(`TOC_OFF_FLAG, 33'h9);
		$display("test 5 done");
		stop_test;
	end
endmodule // testbench

// File: bench/toc_cpu.sv
// cpu model driving the apb register port
module toc_cpu (
	input wire logic clk_in,
	input wire logic pready_in,
	output logic psel_out = 1'b0,
	output logic penable_out = 1'b0,
	output logic pwrite_out = 1'b0,
	output logic [7:0] paddr_out = 8'h00,
	output logic [31:0] pwdata_out = 32'h0
);
	timeunit 1ns;
	timeprecision 1ps;
	// released bus shows inverted address and data, not the last ones
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_in);
		psel_out <= 1'b1;
		pwrite_out <= w;
		paddr_out <= a;
		pwdata_out <= d;
		@(posedge clk_in);
		penable_out <= 1'b1;
		@(posedge clk_in);
		while (pready_in !== 1'b1) @(posedge clk_in);
		psel_out <= 1'b0;
		penable_out <= 1'b0;
		paddr_out <= ~a;
		pwdata_out <= ~d;
	endtask
	task w16(input logic [7:0] a, input logic [15:0] v);
		xfer(1'b1, a + 8'h04, {24'h0, v[15:8]});
		xfer(1'b1, a, {24'h0, v[7:0]});
	endtask
endmodule // toc_cpu

// File: bench/toc_unit_monitor.sv
// port checker for the output compare unit
module toc_unit_monitor (
	input wire logic core_clk_in,
	input wire logic sys_rst_in,
	input wire logic core_ce_in,
	input wire logic timer_tick_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic pready_out,
	input wire logic [2:0] compare_irq_ack_in,
	input wire logic overflow_irq_ack_in,
	input wire logic [2:0] port_value_in,
	input wire logic [2:0] pin_direction_bit_in,
	input wire logic [2:0] pin_out_out,
	input wire logic [2:0] pin_oe_out,
	input wire logic [2:0] compare_irq_out,
	input wire logic overflow_irq_out
);
	// *****
	// properties
	// *****
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (sys_rst_in);
	AST_OE: assert property (pin_oe_out == pin_direction_bit_in) else $error("oe");
	AST_RST: assert property ($fell(sys_rst_in) |-> pin_out_out == port_value_in && compare_irq_out == 3'h0)
		else $error("rst");
	AST_CSET: assert property ($rose(compare_irq_out[0]) && !$past(pwrite_in && pready_out)
		|-> $past(timer_tick_in)) else $error("cset");
	AST_CCLR: assert property ($fell(compare_irq_out[0])
		|-> $past(compare_irq_ack_in[0]) || $past(pwrite_in && pready_out)) else $error("cclr");
	AST_ACK: assert property (compare_irq_ack_in[0] && compare_irq_out[0] && !timer_tick_in && core_ce_in
		|=> !compare_irq_out[0]) else $error("ack");
	AST_OSET: assert property ($rose(overflow_irq_out) && !$past(pwrite_in && pready_out)
		|-> $past(timer_tick_in)) else $error("oset");
	AST_OCLR: assert property ($fell(overflow_irq_out)
		|-> $past(overflow_irq_ack_in) || $past(pwrite_in && pready_out)) else $error("oclr");
	AST_RDY: assert property (psel_in && $rose(penable_in) && core_ce_in |=> pready_out)
		else $error("rdy");
	AST_RDY1: assert property (pready_out |=> !pready_out) else $error("rdy1");
	COV_CMP: cover property ($rose(compare_irq_out[0]));
	COV_OVF: cover property ($rose(overflow_irq_out));
	COV_ACK: cover property ($fell(compare_irq_out[0]));
endmodule // toc_unit_monitor

bind toc_unit toc_unit_monitor u_mon (.*);

// File: design/toc_defs.svh
// register offsets, field positions, reset values and fixed ceilings of the output compare unit
`ifndef TOC_DEFS_SVH
`define TOC_DEFS_SVH

// ************************************************
// register byte offsets
// ************************************************
`define TOC_OFF_CTRL 8'h00
`define TOC_OFF_CNT_L 8'h04
`define TOC_OFF_CNT_H 8'h08
`define TOC_OFF_CMP_L 8'h0c
`define TOC_OFF_CMP_H 8'h10
`define TOC_CMP_STRIDE 8'h08
`define TOC_OFF_IEN 8'h24
`define TOC_OFF_FLAG 8'h28
`define TOC_OFF_FORCE 8'h2c

// ************************************************
// fields and values
// ************************************************
`define TOC_CTRL_MODE_LSB 0
`define TOC_CTRL_ACT_LSB 4
`define TOC_FLAG_OVF_BIT 3
`define TOC_RST_COUNT 16'h0000
`define TOC_RST_CMP 16'h0000
`define TOC_RST_MODE 4'h0
`define TOC_RST_ACT 6'h00
`define TOC_MAX 16'hffff
`define TOC_TOP_8BIT 16'h00ff
`define TOC_TOP_9BIT 16'h01ff
`define TOC_TOP_10BIT 16'h03ff

`endif

// File: design/toc_pkg.sv
// types shared by the output compare unit
package toc_pkg;

	typedef logic [1:0] toc_act_t;

	// all state of the unit
	typedef struct packed {
		logic [15:0] count;
		logic down;
		logic [7:0] temp;
		logic [3:0] mode;
		logic [2:0][1:0] act;
		logic [2:0][15:0] cmp;
		logic [2:0][15:0] cbuf;
		logic [3:0] ien;
		logic [3:0] flag;
		logic [2:0] oc;
		logic block;
		logic ack;
		logic err;
		logic [31:0] rdata;
	} toc_state_s;

endpackage

// File: design/toc_unit.sv
// output compare unit of a 16-bit timer: counter, three compare channels, apb registers
//
// Decided for this implementation: the placing of the registers and the APB slave port.
`include "toc_defs.svh"

// Contract
// - 16-bit equality sets match flag next tick
// - enabled flag requests irq, service clears it
// - writing one to flag bit clears it
// - channel a compare may set counter ceiling
// - compare buffered in pwm, direct otherwise
// - buffer copied only at ceiling or floor
// - cpu reaches buffer if buffered, else active
// - compare changes by cpu only, direct high read
// - high byte to latch, low loads 16 bits
// - force strobe acts like match outside pwm, no flag
// - count write blocks next tick's matches
// - output state survives mode change
// - action bits apply at once, unbuffered
// - reset clears output state to zero
// - nonzero action overrides port value on pin
// - output visible only with direction set
// - action bits never affect counting sequence
// - action zero leaves output state unchanged
// - normal mode counts up, wraps at max
// - overflow flag set as count becomes zero; dual slope sets it as count leaves zero, ctc only on the wrap from max
// - clear-on-match action one toggles output
// - fast pwm two clears on match, three inverse
module toc_unit (
	input wire logic core_clk_in,
	input wire logic sys_rst_in,
	input wire logic core_ce_in,
	input wire logic timer_tick_in,
	input wire logic [15:0] capture_value_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [7:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	input wire logic [2:0] compare_irq_ack_in,
	input wire logic overflow_irq_ack_in,
	input wire logic [2:0] port_value_in,
	input wire logic [2:0] pin_direction_bit_in,
	output logic [2:0] pin_out_out,
	output logic [2:0] pin_oe_out,
	output logic [2:0] compare_irq_out,
	output logic overflow_irq_out
);

	toc_pkg::toc_state_s state_q;
	toc_pkg::toc_state_s state_d;

	logic acc_first;
	logic acc_done;
	logic wr_done;
	logic rd_done;
	logic hit;
	logic [31:0] rd_val;
	logic [7:0] wd;
	logic is_pwm;
	logic is_dual;
	logic is_fast;
	logic var_top;
	logic [15:0] top;
	logic top_hit;
	logic at_floor;
	logic buf_load;
	logic [2:0] match;
	logic [2:0] force_hit;
	logic [3:0] flag_set;
	logic [3:0] flag_clr;
	logic [2:0][15:0] visible;

	// ************************************************
	// mode decode
	// ************************************************
	always_comb begin
		is_pwm = !(state_q.mode == 4'h0 || state_q.mode == 4'h4 || state_q.mode == 4'hc);
		is_dual = (state_q.mode inside {4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'ha, 4'hb});
		is_fast = (state_q.mode inside {4'h5, 4'h6, 4'h7, 4'he, 4'hf});
		var_top = (state_q.mode inside {4'h4, 4'h8, 4'h9, 4'ha, 4'hb, 4'hc, 4'he, 4'hf});
		unique case (state_q.mode)
			4'h1, 4'h5: top = `TOC_TOP_8BIT;
			4'h2, 4'h6: top = `TOC_TOP_9BIT;
			4'h3, 4'h7: top = `TOC_TOP_10BIT;
			4'h4, 4'h9, 4'hb, 4'hf: top = state_q.cmp[0];
			4'h8, 4'ha, 4'hc, 4'he: top = capture_value_in;
			default: top = `TOC_MAX;
		endcase
	end

	// ************************************************
	// bus decode and read mux
	// ************************************************
	always_comb begin
		acc_first = psel_in && penable_in && !state_q.ack;
		acc_done = psel_in && penable_in && state_q.ack;
		wr_done = acc_done && pwrite_in;
		rd_done = acc_done && !pwrite_in;
		wd = pwdata_in[7:0];
		hit = 1'b1;
		rd_val = 32'h0000_0000;
		for (int i = 0; i < 3; i++) begin
			// cpu sees the buffer while buffering is on
			visible[i] = is_pwm ? state_q.cbuf[i] : state_q.cmp[i];
		end
		unique case (paddr_in)
			`TOC_OFF_CTRL: rd_val = {22'h000000, state_q.act, state_q.mode};
			`TOC_OFF_CNT_L: rd_val = {24'h000000, state_q.count[7:0]};
			`TOC_OFF_CNT_H: rd_val = {24'h000000, state_q.temp};
			`TOC_OFF_IEN: rd_val = {28'h0000000, state_q.ien};
			`TOC_OFF_FLAG: rd_val = {28'h0000000, state_q.flag};
			`TOC_OFF_FORCE: rd_val = 32'h0000_0000;
			default: begin
				hit = 1'b0;
				for (int i = 0; i < 3; i++) begin
					if (paddr_in == 8'(`TOC_OFF_CMP_L + i * `TOC_CMP_STRIDE)) begin
						rd_val = {24'h000000, visible[i][7:0]};
						hit = 1'b1;
					end
					if (paddr_in == 8'(`TOC_OFF_CMP_H + i * `TOC_CMP_STRIDE)) begin
						// no latch on the read path: compare never moves by itself
						rd_val = {24'h000000, visible[i][15:8]};
						hit = 1'b1;
					end
				end
			end
		endcase
	end

	// ************************************************
	// counter events
	// ************************************************
	always_comb begin
		// in variable-ceiling modes the ceiling is skipped on the tick after a count write so the count runs on
		top_hit = (state_q.count == top) && !(state_q.block && var_top);
		at_floor = (state_q.count == 16'h0000) && state_q.down;
		if (is_fast) begin
			buf_load = timer_tick_in && top_hit;
		end else if (is_dual) begin
			buf_load = timer_tick_in && ((state_q.mode inside {4'h8, 4'h9}) ? at_floor : (top_hit && !state_q.down));
		end else begin
			buf_load = 1'b0;
		end
		for (int i = 0; i < 3; i++) begin
			match[i] = timer_tick_in && (state_q.count == state_q.cmp[i]) && !state_q.block;
			force_hit[i] = wr_done && !is_pwm && paddr_in == `TOC_OFF_FORCE && wd[i];
		end
	end

	// ************************************************
	// next state
	// ************************************************
	always_comb begin
		state_d = state_q;
		flag_set = 4'h0;
		flag_clr = 4'h0;

		// counting sequence depends on mode bits, count and ceiling only, not on action bits
		if (timer_tick_in) begin
			state_d.block = 1'b0;
			if (is_dual) begin
				if (!state_q.down) begin
					if (top_hit) begin
						state_d.down = 1'b1;
						state_d.count = state_q.count - 16'h0001;
					end else begin
						state_d.count = state_q.count + 16'h0001;
					end
				end else if (state_q.count == 16'h0000) begin
					state_d.down = 1'b0;
					state_d.count = 16'h0001;
					flag_set[`TOC_FLAG_OVF_BIT] = 1'b1;
				end else begin
					state_d.count = state_q.count - 16'h0001;
				end
			end else if (is_fast || state_q.mode == 4'h4 || state_q.mode == 4'hc) begin
				state_d.down = 1'b0;
				if (top_hit) begin
					state_d.count = 16'h0000;
					if (is_fast) begin
						flag_set[`TOC_FLAG_OVF_BIT] = 1'b1;
					end
				end else begin
					state_d.count = state_q.count + 16'h0001;
				end
				if (!is_fast && state_q.count == `TOC_MAX) begin
					flag_set[`TOC_FLAG_OVF_BIT] = 1'b1;
				end
			end else begin
				// normal: up only, wraps at max
				state_d.down = 1'b0;
				state_d.count = state_q.count + 16'h0001;
				if (state_q.count == `TOC_MAX) begin
					flag_set[`TOC_FLAG_OVF_BIT] = 1'b1;
				end
			end
		end

		if (buf_load) begin
			state_d.cmp = state_q.cbuf;
		end

		// ************************************************
		// waveform generator per channel
		// ************************************************
		for (int i = 0; i < 3; i++) begin
			flag_set[i] = match[i];
			if (!is_pwm) begin
				if (match[i] || force_hit[i]) begin
					unique case (state_q.act[i])
						2'h1: state_d.oc[i] = !state_q.oc[i];
						2'h2: state_d.oc[i] = 1'b0;
						2'h3: state_d.oc[i] = 1'b1;
						default: state_d.oc[i] = state_q.oc[i];
					endcase
				end
			end else if (is_fast) begin
				if (timer_tick_in && top_hit && state_q.act[i][1]) begin
					state_d.oc[i] = !state_q.act[i][0];
				end else if (match[i]) begin
					if (state_q.act[i][1]) begin
						state_d.oc[i] = state_q.act[i][0];
					end else if (i == 0 && state_q.act[i] == 2'h1 && state_q.mode == 4'hf) begin
						state_d.oc[i] = !state_q.oc[i];
					end
				end
			end else if (match[i] && state_q.act[i][1]) begin
				// dual slope: upcount match acts as fast pwm, downcount inverts
				state_d.oc[i] = state_q.act[i][0] ^ state_q.down;
			end
		end

		// ************************************************
		// apb access
		// ************************************************
		if (acc_first) begin
			state_d.ack = 1'b1;
			state_d.rdata = rd_val;
			state_d.err = !hit;
		end
		if (acc_done) begin
			state_d.ack = 1'b0;
		end
		if (rd_done && paddr_in == `TOC_OFF_CNT_L) begin
			state_d.temp = state_q.count[15:8];
		end
		if (wr_done) begin
			unique case (paddr_in)
				`TOC_OFF_CTRL: begin
					state_d.mode = pwdata_in[`TOC_CTRL_MODE_LSB +: 4];
					// takes effect at once, oc itself is left alone
					state_d.act = pwdata_in[`TOC_CTRL_ACT_LSB +: 6];
				end
				`TOC_OFF_CNT_H: state_d.temp = wd;
				`TOC_OFF_CNT_L: begin
					// cpu write wins over counting and blocks matches on the next tick
					state_d.count = {state_q.temp, wd};
					state_d.block = 1'b1;
				end
				`TOC_OFF_IEN: state_d.ien = pwdata_in[3:0];
				`TOC_OFF_FLAG: flag_clr = pwdata_in[3:0];
				default: begin
					for (int i = 0; i < 3; i++) begin
						if (paddr_in == 8'(`TOC_OFF_CMP_H + i * `TOC_CMP_STRIDE)) begin
							state_d.temp = wd;
						end
						if (paddr_in == 8'(`TOC_OFF_CMP_L + i * `TOC_CMP_STRIDE)) begin
							if (is_pwm) begin
								state_d.cbuf[i] = {state_q.temp, wd};
							end else begin
								state_d.cmp[i] = {state_q.temp, wd};
							end
						end
					end
				end
			endcase
		end

		// service acknowledge clears; a new event in the same cycle still wins
		flag_clr = flag_clr | ({overflow_irq_ack_in, compare_irq_ack_in} & state_q.ien);
		state_d.flag = (state_q.flag & ~flag_clr) | flag_set;
	end

	// ************************************************
	// state register
	// ************************************************
	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			state_q.count <= `TOC_RST_COUNT;
			state_q.down <= 1'b0;
			state_q.temp <= 8'h00;
			state_q.mode <= `TOC_RST_MODE;
			state_q.act <= `TOC_RST_ACT;
			state_q.cmp <= {3{`TOC_RST_CMP}};
			state_q.cbuf <= {3{`TOC_RST_CMP}};
			state_q.ien <= 4'h0;
			state_q.flag <= 4'h0;
			state_q.oc <= 3'h0;
			state_q.block <= 1'b0;
			state_q.ack <= 1'b0;
			state_q.err <= 1'b0;
			state_q.rdata <= 32'h0000_0000;
		end else if (core_ce_in) begin
			state_q <= state_d;
		end
	end

	// ************************************************
	// outputs
	// ************************************************
	always_comb begin
		prdata_out = state_q.rdata;
		pready_out = state_q.ack;
		pslverr_out = state_q.ack && state_q.err;
		compare_irq_out = state_q.flag[2:0] & state_q.ien[2:0];
		overflow_irq_out = state_q.flag[`TOC_FLAG_OVF_BIT] && state_q.ien[`TOC_FLAG_OVF_BIT];
		for (int i = 0; i < 3; i++) begin
			pin_out_out[i] = (state_q.act[i] != 2'h0) ? state_q.oc[i] : port_value_in[i];
			pin_oe_out[i] = pin_direction_bit_in[i];
		end
	end

endmodule // toc_unit
